// ---- amrc_pkg.sv ----
// Package for the auxiliary Manchester request checker
package amrc_pkg;
    // Bit time and tolerance in nanoseconds
    localparam int BIT_NS = 6000;
    localparam int TOL_LATE_NS = 2000;
    localparam int TOL_EARLY_NS = 1000;
    localparam int CLK_NS = 4;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(BIT_NS / CLK_NS);
    localparam logic [CNT_W-1:0] LATE_CYC = CNT_W'(TOL_LATE_NS / CLK_NS);
    localparam logic [CNT_W-1:0] EARLY_CYC = CNT_W'((TOL_EARLY_NS + CLK_NS - 1) / CLK_NS);
    // Transition index of end bit, info bit count, pause bit times
    localparam logic [4:0] END_IDX = 5'h0d;
    localparam logic [4:0] SYNC_PAUSE_BITS = 5'h01;
    localparam logic [4:0] ASYNC_PAUSE_BITS = 5'h03;
    localparam int DATA_W = 12;
    // Status word bit positions
    localparam int ST_WRITE_BLOCKED = 0;
    localparam int ST_PERIPH_FAULT = 1;
    localparam int ST_UNUSED = 2;
    localparam int ST_MEM_CORRUPT = 3;

    typedef enum logic [1:0] {
        MODE_SLAVE,
        MODE_MASTER,
        MODE_REPEATER,
        MODE_MONITOR
    } amrc_mode_t;

    typedef struct packed {
        logic start_err;
        logic no_info_err;
        logic parity_err;
        logic end_err;
        logic length_err;
    } amrc_err_t;

    typedef struct packed {
        logic write_active;
        logic delete_address_request;
        logic address_nonzero;
        logic periph_fault;
        logic firmware_parity_err;
        logic mem_corrupt;
        logic read_status_request;
    } amrc_stat_in_t;
endpackage

// ---- amrc_checker.sv ----
// Auxiliary channel Manchester request receiver, checker and status word
// Summary of operation
// R01: Aux input idle high between telegrams
// R02: Falling start, rising end, then pause
// R03: Mid-bit falling is zero, rising is one
// R04: Error checks only in slave mode
// R05: Other modes pass input straight to transmitter
// R06: No receive strobe outside slave mode
// R07: External master must time waveforms correctly
// R08: Rising first transition flags start fault
// R09: Transitions at n*6us, +2/-1us, else fault
// R10: Only master requests accepted in slave mode
// R11: Ones count including parity must be even
// R12: Transition at 78us must rise, ends request
// R13: Activity after end bit flags length fault
// R14: Fault discards telegram, async, await pause
// R15: Strobe starts processing, async becomes sync
// R16: Mode selected from stored configuration
// R17: Decoded request presented for reply computation
// R18: Prohibited state forces slave reset
// R19: Status word returned, bit two zero
// R20: Status bit zero: writing or address deleted
// R21: Status bit one: peripheral or parity fault
// R22: Status bit three: memory corrupted
// R23: Input synchronised, windows counted in cycles
`timescale 1ns/1ps
`default_nettype none
module amrc_checker (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic aux_address_input_i,
    input wire amrc_pkg::amrc_mode_t cfg_mode_i,
    input wire amrc_pkg::amrc_stat_in_t stat_i,
    output logic line_tx_o,
    output logic rx_strobe_o,
    output logic [amrc_pkg::DATA_W-1:0] rx_data_o,
    output amrc_pkg::amrc_err_t err_o,
    output logic synced_o,
    output logic reset_slave_o,
    output logic [3:0] slave_status_word_o,
    output logic status_valid_o
);
    import amrc_pkg::*;

    typedef enum logic [2:0] {
        ST_WAIT_PAUSE,
        ST_IDLE,
        ST_RECV,
        ST_TAIL
    } amrc_state_t;

    logic sync1_q, sync2_q, prev_q;
    logic sync1_d, sync2_d, prev_d;
    logic line_rise, line_fall;
    amrc_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] due_q, due_d;
    logic [4:0] idx_q, idx_d;
    logic [4:0] quiet_q, quiet_d;
    logic [DATA_W-1:0] shreg_q, shreg_d;
    logic par_q, par_d;
    logic synced_q, synced_d;
    logic strobe_q, strobe_d;
    logic [DATA_W-1:0] data_q, data_d;
    amrc_err_t err_q, err_d;
    logic rst_slave_q, rst_slave_d;
    logic [3:0] status_q, status_d;
    logic stval_q, stval_d;
    logic deleted_q, deleted_d;
    logic slave_mode;
    logic in_window, past_window;
    logic [CNT_W-1:0] win_lo, win_hi;
    logic [4:0] quiet_need;

    // Two flops before the receive logic reads the pin [R23]
    always_comb begin
        sync1_d = aux_address_input_i;
        sync2_d = sync1_q;
        prev_d = sync2_q;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

    assign line_fall = prev_q & ~sync2_q;
    assign line_rise = ~prev_q & sync2_q;
    assign slave_mode = (cfg_mode_i == MODE_SLAVE); // [R16]
    // Raw pin to transmitter: no delay stages, only valid level logic [R05]
    assign line_tx_o = slave_mode ? 1'b1 : aux_address_input_i;
    // Deadlines run from the start edge, so edge jitter cannot pile up [R09]
    assign win_lo = due_q - EARLY_CYC;
    assign win_hi = due_q + LATE_CYC;
    assign in_window = (cnt_q >= win_lo) && (cnt_q <= win_hi);
    assign past_window = (cnt_q > win_hi);
    // Synced slaves check one quiet bit time, others three [R13]
    assign quiet_need = synced_q ? SYNC_PAUSE_BITS : ASYNC_PAUSE_BITS;

    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1);
        idx_d = idx_q;
        due_d = due_q;
        quiet_d = quiet_q;
        shreg_d = shreg_q;
        par_d = par_q;
        synced_d = synced_q;
        strobe_d = 1'b0;
        data_d = data_q;
        err_d = '0;
        rst_slave_d = 1'b0;
        if (!slave_mode) begin
            // Checking off; the receiver rests waiting for a pause [R04] [R06]
            state_d = ST_WAIT_PAUSE;
            cnt_d = '0;
            // Mode change drops any half-received request
            idx_d = '0;
            quiet_d = '0;
            par_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_WAIT_PAUSE: begin
                    // Pause means one bit time of steady high [R01] [R14]
                    if (!sync2_q || line_rise) begin
                        cnt_d = '0;
                    end else if (cnt_q >= BIT_CYC) begin
                        state_d = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    cnt_d = '0;
                    idx_d = '0;
                    par_d = 1'b0;
                    due_d = BIT_CYC;
                    if (line_fall) begin
                        state_d = ST_RECV; // [R02]
                    end else if (!sync2_q) begin
                        // Low without a falling edge: bad start [R08]
                        err_d.start_err = 1'b1;
                        synced_d = 1'b0;
                        state_d = ST_WAIT_PAUSE;
                    end
                end
                ST_RECV: begin
                    // Earlier edges sit on bit boundaries and carry no data [R03]
                    if ((line_fall || line_rise) && in_window) begin
                        if (idx_q + 5'h01 == END_IDX) begin
                            // End bit must rise [R12]
                            cnt_d = '0;
                            if (!line_rise) begin
                                err_d.end_err = 1'b1;
                                synced_d = 1'b0;
                                state_d = ST_WAIT_PAUSE;
                            end else if (par_q) begin
                                err_d.parity_err = 1'b1; // [R11]
                                synced_d = 1'b0;
                                state_d = ST_WAIT_PAUSE;
                            end else begin
                                quiet_d = '0;
                                state_d = ST_TAIL;
                            end
                        end else begin
                            // Rising is one, falling is zero [R03]
                            shreg_d = {shreg_q[DATA_W-2:0], line_rise};
                            par_d = par_q ^ line_rise; // [R11]
                            idx_d = idx_q + 5'h01;
                            due_d = due_q + BIT_CYC;
                        end
                    end else if (past_window) begin
                        err_d.no_info_err = 1'b1; // [R09]
                        synced_d = 1'b0;
                        state_d = ST_WAIT_PAUSE;
                        cnt_d = '0;
                    end
                end
                ST_TAIL: begin
                    // Quiet bit times after the end bit [R13]
                    if (!sync2_q || line_fall) begin
                        err_d.length_err = 1'b1;
                        synced_d = 1'b0;
                        state_d = ST_WAIT_PAUSE;
                        cnt_d = '0;
                    end else if (cnt_q >= BIT_CYC) begin
                        cnt_d = '0;
                        quiet_d = quiet_q + 5'h01;
                        if (quiet_q + 5'h01 == quiet_need) begin
                            // Master request only: 12 info bits [R10] [R15] [R17]
                            strobe_d = 1'b1;
                            data_d = shreg_q;
                            synced_d = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    // Prohibited code: recover like a slave reset [R18]
                    rst_slave_d = 1'b1;
                    synced_d = 1'b0;
                    state_d = ST_WAIT_PAUSE;
                    cnt_d = '0;
                    idx_d = '0;
                    quiet_d = '0;
                    par_d = 1'b0;
                    shreg_d = '0;
                    data_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_WAIT_PAUSE;
            cnt_q <= '0;
            due_q <= BIT_CYC;
            idx_q <= '0;
            quiet_q <= '0;
            shreg_q <= '0;
            par_q <= 1'b0;
            synced_q <= 1'b0;
            strobe_q <= 1'b0;
            data_q <= '0;
            err_q <= '0;
            rst_slave_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            due_q <= due_d;
            idx_q <= idx_d;
            quiet_q <= quiet_d;
            shreg_q <= shreg_d;
            par_q <= par_d;
            synced_q <= synced_d;
            strobe_q <= strobe_d;
            data_q <= data_d;
            err_q <= err_d;
            rst_slave_q <= rst_slave_d;
        end
    end

    // Delete latch; cleared by slave reset, set wins
    always_comb begin
        deleted_d = deleted_q;
        if (rst_slave_q) begin
            deleted_d = 1'b0;
        end
        if (stat_i.delete_address_request && stat_i.address_nonzero) begin
            deleted_d = 1'b1; // [R20]
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deleted_q <= 1'b0;
        end else begin
            deleted_q <= deleted_d;
        end
    end

    // Status word, captured on each read request
    always_comb begin
        status_d = status_q;
        stval_d = 1'b0;
        if (rst_slave_q) begin
            status_d = '0; // [R18]
        end
        if (stat_i.read_status_request) begin
            status_d[ST_WRITE_BLOCKED] = stat_i.write_active | deleted_q; // [R20]
            status_d[ST_PERIPH_FAULT] = stat_i.periph_fault | stat_i.firmware_parity_err; // [R21]
            status_d[ST_UNUSED] = 1'b0; // [R19]
            status_d[ST_MEM_CORRUPT] = stat_i.mem_corrupt; // [R22]
            stval_d = 1'b1; // [R19]
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= '0;
            stval_q <= 1'b0;
        end else begin
            status_q <= status_d;
            stval_q <= stval_d;
        end
    end

    assign rx_strobe_o = strobe_q;
    assign rx_data_o = data_q;
    assign err_o = err_q;
    assign synced_o = synced_q;
    assign reset_slave_o = rst_slave_q;
    assign slave_status_word_o = status_q;
    assign status_valid_o = stval_q;
endmodule // amrc_checker
`default_nettype wire

// ---- amrc_checker_chk.sv ----
// Port assertions for the aux request checker
`timescale 1ns/1ps
`default_nettype none
module amrc_checker_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic aux_address_input_i,
    input wire amrc_pkg::amrc_mode_t cfg_mode_i,
    input wire amrc_pkg::amrc_stat_in_t stat_i,
    input wire logic line_tx_o,
    input wire logic rx_strobe_o,
    input wire logic [amrc_pkg::DATA_W-1:0] rx_data_o,
    input wire amrc_pkg::amrc_err_t err_o,
    input wire logic synced_o,
    input wire logic reset_slave_o,
    input wire logic [3:0] slave_status_word_o,
    input wire logic status_valid_o
);
    import amrc_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_pass; cfg_mode_i != MODE_SLAVE |-> line_tx_o == aux_address_input_i; endproperty
    a_pass: assert property (p_pass) else $error("pass-through differs");
    property p_nostb; rx_strobe_o |-> cfg_mode_i == MODE_SLAVE; endproperty
    a_nostb: assert property (p_nostb) else $error("strobe outside slave mode");
    property p_noerr; err_o != '0 |-> cfg_mode_i == MODE_SLAVE; endproperty
    a_noerr: assert property (p_noerr) else $error("fault outside slave mode");
    property p_par; rx_strobe_o |-> (^rx_data_o) == 1'b0; endproperty
    a_par: assert property (p_par) else $error("odd data accepted");
    property p_clean; rx_strobe_o |-> err_o == '0; endproperty
    a_clean: assert property (p_clean) else $error("strobe with fault");
    property p_desync; err_o != '0 |=> !synced_o; endproperty
    a_desync: assert property (p_desync) else $error("sync kept after fault");
    property p_sync; rx_strobe_o |=> synced_o; endproperty
    a_sync: assert property (p_sync) else $error("no sync after strobe");
    property p_stat; stat_i.read_status_request |=> status_valid_o && slave_status_word_o[3:1]
        == {$past(stat_i.mem_corrupt), 1'b0,
        $past(stat_i.periph_fault) || $past(stat_i.firmware_parity_err)}; endproperty
    a_stat: assert property (p_stat) else $error("status word wrong");
    property p_wr; stat_i.read_status_request && stat_i.write_active |=> slave_status_word_o[0];
    endproperty
    a_wr: assert property (p_wr) else $error("write bit low");
endmodule // amrc_checker_chk
`default_nettype wire

// ---- amrc_master_model.sv ----
// Master-side driver of the aux Manchester input
`timescale 1ns/1ps
`default_nettype none
module amrc_master_model (
    input wire logic mclk_i,
    output logic aux_o
);
    initial aux_o = 1'b1; // Idle high between telegrams
    task automatic half();
        repeat (750) @(negedge mclk_i);
    endtask
    // Only master requests are sent, never responses
    task automatic send(input logic [11:0] d, input int nb, input bit ex);
        int i;
        aux_o = 1'b0; // Start bit falls mid-bit
        for (i = 0; i < nb; i++) begin
            half();
            aux_o = ~d[11-i];
            half();
            aux_o = d[11-i]; // Mid-bit edges 1500 cycles apart
        end
        if (nb == 12) begin
            half();
            aux_o = 1'b0;
            half();
            aux_o = 1'b1; // Rising end in 13th slot
            if (ex) begin
                half();
                aux_o = 1'b0; // Glitch inside the quiet time
                repeat (50) @(negedge mclk_i);
                aux_o = 1'b1;
            end
        end else begin
            // Short frame: edge goes missing on purpose
            repeat (nb == 0 ? 1200 : 2500) @(negedge mclk_i);
            aux_o = 1'b1;
        end
    endtask
endmodule // amrc_master_model
`default_nettype wire

// ---- amrc_checker_tb_top.sv ----
// Testbench for the aux request checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) if ((g) !== (e)) begin $display("Error %s exp %h got %h", n, e, g); err_total++; end tests_run++;
module amrc_checker_tb_top;
    import amrc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wire aux;
    amrc_mode_t cfg_mode_i = MODE_SLAVE;
    amrc_stat_in_t stat_i = '0;
    logic line_tx_o, rx_strobe_o, synced_o, reset_slave_o, status_valid_o;
    logic [DATA_W-1:0] rx_data_o;
    logic [3:0] slave_status_word_o;
    amrc_err_t err_o, err_seen;
    int n_strobe, err_total, tests_run;
    logic mon_clr = 1'b0;
    logic rs_seen;
    logic [6:0] st_tab [6] = '{7'h01, 7'h41, 7'h09, 7'h05, 7'h03, 7'h01};
    logic [3:0] st_exp [6] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h8, 4'h1};
    amrc_checker dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .aux_address_input_i(aux),
        .cfg_mode_i(cfg_mode_i), .stat_i(stat_i), .line_tx_o(line_tx_o),
        .rx_strobe_o(rx_strobe_o), .rx_data_o(rx_data_o), .err_o(err_o), .synced_o(synced_o),
        .reset_slave_o(reset_slave_o), .slave_status_word_o(slave_status_word_o),
        .status_valid_o(status_valid_o));
    amrc_master_model partner (.mclk_i(mclk_i), .aux_o(aux));
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (mon_clr) begin
            n_strobe <= 0;
            err_seen <= '0;
            rs_seen <= 1'b0;
        end else begin
            n_strobe <= n_strobe + int'(rx_strobe_o === 1'b1);
            err_seen <= err_seen | err_o;
            rs_seen <= rs_seen | reset_slave_o;
        end
    end
    task automatic final_report();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Long wait only where a strobe may still be due
    task automatic run(input amrc_mode_t m, input logic [11:0] d, input int nb, input bit ex,
        input int exp_s, input amrc_err_t exp_e);
        cfg_mode_i = m;
        mon_clr = 1'b1;
        @(negedge mclk_i);
        mon_clr = 1'b0;
        fork
            partner.send(d, nb, ex);
            repeat (3) begin
                repeat (350) @(negedge mclk_i);
                `CHK("line_tx", (m == MODE_SLAVE) ? 1'b1 : aux, line_tx_o)
            end
        join
        repeat (exp_s > 0 ? 4800 : (m == MODE_SLAVE ? 2000 : 200)) @(negedge mclk_i);
        `CHK("strobes", exp_s, n_strobe)
        `CHK("errors", exp_e, err_seen)
        `CHK("reset_slave", 1'b0, rs_seen)
    endtask
    initial begin
        int i;
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        `CHK("status", 4'h0, slave_status_word_o)
        `CHK("synced", 1'b0, synced_o)
        repeat (2000) @(negedge mclk_i);
        run(MODE_SLAVE, 12'h5a3, 12, 1'b0, 1, 5'h00);
        `CHK("data", 12'h5a3, rx_data_o)
        `CHK("synced", 1'b1, synced_o)
        run(MODE_SLAVE, 12'h5a3, 12, 1'b1, 0, 5'h01);
        run(MODE_SLAVE, 12'h001, 12, 1'b0, 0, 5'h04);
        `CHK("synced", 1'b0, synced_o)
        run(MODE_SLAVE, 12'h5a3, 3, 1'b0, 0, 5'h08);
        for (i = 1; i < 4; i++) begin
            run(amrc_mode_t'(i), 12'h000, 0, 1'b0, 0, 5'h00);
        end
        for (i = 0; i < 6; i++) begin
            if (i == 5) begin
                stat_i = 7'h30;
                @(negedge mclk_i);
            end
            stat_i = st_tab[i];
            @(negedge mclk_i);
            stat_i = '0;
            `CHK("status_valid", 1'b1, status_valid_o)
            `CHK("status", st_exp[i], slave_status_word_o)
            @(negedge mclk_i);
        end
        final_report();
    end
    initial begin
        repeat (95000) @(posedge mclk_i);
        err_total++;
        final_report();
    end
endmodule // amrc_checker_tb_top
bind amrc_checker amrc_checker_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .aux_address_input_i(aux_address_input_i), .cfg_mode_i(cfg_mode_i), .stat_i(stat_i),
    .line_tx_o(line_tx_o), .rx_strobe_o(rx_strobe_o), .rx_data_o(rx_data_o), .err_o(err_o),
    .synced_o(synced_o), .reset_slave_o(reset_slave_o),
    .slave_status_word_o(slave_status_word_o), .status_valid_o(status_valid_o));
`default_nettype wire
